// file: design/lpcd_pkg.sv
// Shared constants and types of the low-power DDR command decoder.
// Assumes a 200 MHz system clock that oversamples the memory link pins.
package lpcd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths of the command and data pins, bank count, auto precharge bit position and timer width.
	localparam int unsigned BANK_W = 2;
	localparam int unsigned NUM_BANKS = 4;
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned MASK_W = 2;
	localparam int unsigned AP_BIT = 10;
	localparam int unsigned TIMER_W = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Timing in nanoseconds and the derived counts of system clocks, rounded up.
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned PRECHARGE_TIME_NS = 15;
	localparam int unsigned REFRESH_CYCLE_TIME_NS = 80;
	localparam int unsigned MODE_LOAD_DELAY_NS = 10;
	localparam logic [TIMER_W-1:0] PRECHARGE_CYC =
		TIMER_W'((PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TIMER_W-1:0] REFRESH_CYC =
		TIMER_W'((REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [TIMER_W-1:0] MODE_LOAD_CYC =
		TIMER_W'((MODE_LOAD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	// Link clock edges per burst; a burst of two words takes two edges.
	localparam logic [2:0] BURST_EDGES = 3'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [TIMER_W-1:0] TIMER_RST = 8'h00;
	localparam logic [ADDR_W-1:0] REFRESH_ROW_RST = 13'h0000;
	localparam logic [NUM_BANKS-1:0] BANKS_RST = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Decoded commands.
	typedef enum logic [3:0] {
		LPCD_CMD_NONE = 4'h0,
		LPCD_CMD_ACT = 4'h1,
		LPCD_CMD_RD = 4'h2,
		LPCD_CMD_WR = 4'h3,
		LPCD_CMD_BST = 4'h4,
		LPCD_CMD_DPD = 4'h5,
		LPCD_CMD_PRE = 4'h6,
		LPCD_CMD_PREALL = 4'h7,
		LPCD_CMD_AREF = 4'h8,
		LPCD_CMD_SREF = 4'h9,
		LPCD_CMD_MRS = 4'ha
	} lpcd_cmd_t;

	// All link pins, sampled together.
	typedef struct packed {
		logic ck;
		logic ck_n;
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BANK_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
		logic [MASK_W-1:0] mask;
		logic [DATA_W-1:0] dq;
	} lpcd_pins_t;

	// One write word on its way to the array, with byte enables.
	typedef struct packed {
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] col;
		logic [MASK_W-1:0] strb;
		logic [DATA_W-1:0] data;
	} lpcd_wr_word_t;

endpackage : lpcd_pkg

// file: design/lpcd_buf_if.sv
// Valid/ready carrier between the decoder and its write buffer.
// Assumes lpcd_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface lpcd_buf_if;
	logic in_valid;
	logic in_ready;
	lpcd_pkg::lpcd_wr_word_t in_word;
	logic out_valid;
	logic out_ready;
	lpcd_pkg::lpcd_wr_word_t out_word;

	modport fill (output in_valid, in_word, out_ready, input in_ready, out_valid, out_word);
	modport store (input in_valid, in_word, out_ready, output in_ready, out_valid, out_word);
endinterface : lpcd_buf_if
`default_nettype wire

// file: design/lpcd_wr_buf.sv
// Two-entry write buffer; both handshake sides come straight from flip-flops.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lpcd_wr_buf (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	lpcd_buf_if.store bp
);
	import lpcd_pkg::*;

	lpcd_wr_word_t head;
	lpcd_wr_word_t tail;
	logic head_v;
	logic tail_v;

	// Ready depends only on the tail slot, so it never loops back combinationally.
	wire pop = head_v & bp.out_ready;
	wire push = bp.in_valid & ~tail_v;
	assign bp.in_ready = ~tail_v;
	assign bp.out_valid = head_v;
	assign bp.out_word = head;

	// Head drains first; the tail only fills while the head is held.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			head_v <= 1'b0;
			tail_v <= 1'b0;
			head <= '0;
			tail <= '0;
		end else if (pop && tail_v) begin
			head <= tail;
			tail_v <= 1'b0;
		end else if (pop) begin
			head_v <= push;
			head <= bp.in_word;
		end else if (push && head_v) begin
			tail <= bp.in_word;
			tail_v <= 1'b1;
		end else if (push) begin
			head <= bp.in_word;
			head_v <= 1'b1;
		end
	end

	c_buf_full: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) head_v && tail_v);

endmodule : lpcd_wr_buf
`default_nettype wire

// file: design/lpcd_decoder.sv
// Command decoder and bank tracker of a low-power DDR memory, device side.
// Assumes link pins are asynchronous to sys_clk_i and the link clock is far slower.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Commands taken only on true link clock rise.
// - Chip select high ignores all command inputs.
// - No-op encoding behaves like deselect.
// - Activate opens addressed row in chosen bank.
// - Row stays open until precharged; deep power-down entry also closes it.
// - Read starts burst at bank and column.
// - Write starts burst at bank and column.
// - Auto precharge bit applies per command only.
// - Auto precharge closes row at burst end.
// - Masked write bytes leave storage unchanged.
// - Precharge closes one bank or all banks.
// - Precharged bank usable only after precharge time.
// - Burst terminate truncates latest read, page open.
// - Terminate encoding, clock enable low: deep power-down.
// - Auto refresh uses internal row counter.
// - Each refresh occupies refresh cycle time.
// - Refresh encoding, clock enable low: self refresh.
// - Mode load selects register by bank address.
module lpcd_decoder (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic link_ck_i,
	input wire logic link_ck_n_i,
	input wire logic clock_enable_i,
	input wire logic chip_select_n_i,
	input wire logic row_strobe_n_i,
	input wire logic column_strobe_n_i,
	input wire logic write_enable_n_i,
	input wire logic [lpcd_pkg::BANK_W-1:0] bank_addr_i,
	input wire logic [lpcd_pkg::ADDR_W-1:0] addr_i,
	input wire logic [lpcd_pkg::MASK_W-1:0] write_mask_i,
	input wire logic [lpcd_pkg::DATA_W-1:0] dq_i,
	input wire logic array_wr_ready_i,
	output logic cmd_valid_o,
	output lpcd_pkg::lpcd_cmd_t cmd_code_o,
	output logic [lpcd_pkg::BANK_W-1:0] cmd_bank_o,
	output logic [lpcd_pkg::ADDR_W-1:0] cmd_addr_o,
	output logic cmd_auto_pre_o,
	output logic [lpcd_pkg::NUM_BANKS-1:0] bank_open_o,
	output logic [lpcd_pkg::NUM_BANKS-1:0] bank_ready_o,
	output logic rd_burst_o,
	output logic wr_burst_o,
	output logic refreshing_o,
	output logic [lpcd_pkg::ADDR_W-1:0] refresh_row_o,
	output logic mode_load_o,
	output logic mode_busy_o,
	output logic [lpcd_pkg::BANK_W-1:0] mode_sel_o,
	output logic [lpcd_pkg::ADDR_W-1:0] mode_op_o,
	output logic self_refresh_o,
	output logic deep_power_down_o,
	output logic wr_overflow_o,
	output logic array_wr_valid_o,
	output lpcd_pkg::lpcd_wr_word_t array_wr_word_o
);
	import lpcd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Command truth table; clock enable splits terminate and refresh encodings.
	function automatic lpcd_cmd_t lpcd_decode(input lpcd_pins_t p);
		lpcd_cmd_t c;
		c = LPCD_CMD_NONE;
		if (!p.cs_n) begin
			case ({p.ras_n, p.cas_n, p.we_n})
				3'h3: c = LPCD_CMD_ACT;
				3'h5: c = LPCD_CMD_RD;
				3'h4: c = LPCD_CMD_WR;
				3'h6: c = p.cke ? LPCD_CMD_BST : LPCD_CMD_DPD;
				3'h2: c = p.addr[AP_BIT] ? LPCD_CMD_PREALL : LPCD_CMD_PRE;
				3'h1: c = p.cke ? LPCD_CMD_AREF : LPCD_CMD_SREF;
				3'h0: c = LPCD_CMD_MRS;
				default: c = LPCD_CMD_NONE;
			endcase
		end
		return c;
	endfunction : lpcd_decode

	lpcd_pins_t pin_raw;
	lpcd_pins_t pin_s1;
	lpcd_pins_t pin_s2;
	logic ck_prev;
	logic [NUM_BANKS-1:0][TIMER_W-1:0] pre_timer;
	logic [NUM_BANKS-1:0][ADDR_W-1:0] bank_row;
	logic [NUM_BANKS-1:0] bank_close;
	logic [NUM_BANKS-1:0] bank_ready_now;
	logic [BANK_W-1:0] rd_bank;
	logic [BANK_W-1:0] wr_bank;
	logic rd_ap;
	logic wr_ap;
	logic [2:0] rd_left;
	logic [2:0] wr_left;
	logic [ADDR_W-1:0] wr_col;
	logic [TIMER_W-1:0] ref_timer;
	logic [TIMER_W-1:0] mrs_timer;
	logic cap_valid;
	lpcd_wr_word_t cap_word;
	lpcd_buf_if wbuf ();

	////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser for every pin; only the second stage is read.
	assign pin_raw = '{link_ck_i, link_ck_n_i, clock_enable_i, chip_select_n_i,
		row_strobe_n_i, column_strobe_n_i, write_enable_n_i, bank_addr_i, addr_i,
		write_mask_i, dq_i};

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			ck_prev <= 1'b0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			ck_prev <= pin_s2.ck;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Positive link edge: true clock rising while the complement sits low.
	wire ck_edge = pin_s2.ck & ~ck_prev & ~pin_s2.ck_n;
	wire lpcd_cmd_t dec_cmd = lpcd_decode(pin_s2);
	wire [BANK_W-1:0] dec_ba = pin_s2.ba;
	wire dec_ap = pin_s2.addr[AP_BIT];

	// Refresh and mode loads lock out further commands; bursts keep counting.
	wire dev_busy = self_refresh_o | deep_power_down_o | (ref_timer != TIMER_RST)
		| (mrs_timer != TIMER_RST);
	wire take = ck_edge & ~dev_busy;
	wire all_idle = &bank_ready_now;
	wire no_burst = ~rd_burst_o & ~wr_burst_o;
	wire take_act = take & (dec_cmd == LPCD_CMD_ACT) & bank_ready_now[dec_ba];
	wire take_rd = take & (dec_cmd == LPCD_CMD_RD) & bank_open_o[dec_ba];
	wire take_wr = take & (dec_cmd == LPCD_CMD_WR) & bank_open_o[dec_ba];
	wire take_bst = take & (dec_cmd == LPCD_CMD_BST) & rd_burst_o & ~rd_ap;
	wire take_dpd = take & (dec_cmd == LPCD_CMD_DPD);
	wire take_pre = take & (dec_cmd == LPCD_CMD_PRE);
	wire take_preall = take & (dec_cmd == LPCD_CMD_PREALL);
	wire take_aref = take & (dec_cmd == LPCD_CMD_AREF) & all_idle & no_burst;
	wire take_sref = take & (dec_cmd == LPCD_CMD_SREF) & all_idle & no_burst;
	wire take_mrs = take & (dec_cmd == LPCD_CMD_MRS) & all_idle & no_burst;
	wire any_take = take_act | take_rd | take_wr | take_bst | take_dpd | take_pre
		| take_preall | take_aref | take_sref | take_mrs;
	wire rd_end = ck_edge & rd_burst_o & (rd_left == 3'h1);
	wire wr_end = ck_edge & wr_burst_o & (wr_left == 3'h1);

	// Per-bank close: explicit precharge or auto precharge at burst end.
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		assign bank_ready_now[b] = ~bank_open_o[b] & (pre_timer[b] == TIMER_RST);
		assign bank_close[b] = bank_open_o[b] & (take_preall
			| (take_pre & (dec_ba == BANK_W'(b)))
			| (rd_end & rd_ap & (rd_bank == BANK_W'(b)))
			| (wr_end & wr_ap & (wr_bank == BANK_W'(b))));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bank state: open flag, open row and the precharge wait.
	always_ff @(posedge sys_clk_i) begin
		for (int b = 0; b < NUM_BANKS; b++) begin
			if (!rst_n_i || take_dpd) begin
				bank_open_o[b] <= 1'b0;
				pre_timer[b] <= TIMER_RST;
				bank_row[b] <= '0;
			end else if (bank_close[b]) begin
				bank_open_o[b] <= 1'b0;
				pre_timer[b] <= PRECHARGE_CYC;
			end else if (take_act && dec_ba == BANK_W'(b)) begin
				bank_open_o[b] <= 1'b1;
				bank_row[b] <= pin_s2.addr;
			end else if (pre_timer[b] != TIMER_RST) begin
				pre_timer[b] <= pre_timer[b] - 8'h01;
			end
		end
		bank_ready_o <= rst_n_i ? bank_ready_now : BANKS_RST;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read burst; a new read, a write, a terminate or a precharge of its bank truncates it.
	wire rd_cut = take_bst | take_wr | take_preall | (take_pre & dec_ba == rd_bank);
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rd_burst_o <= 1'b0;
			rd_bank <= '0;
			rd_ap <= 1'b0;
			rd_left <= 3'h0;
		end else if (take_rd) begin
			rd_burst_o <= 1'b1;
			rd_bank <= dec_ba;
			rd_ap <= dec_ap;
			rd_left <= BURST_EDGES;
		end else if (rd_cut || rd_end) begin
			rd_burst_o <= 1'b0;
		end else if (ck_edge && rd_burst_o) begin
			rd_left <= rd_left - 3'h1;
		end
	end

	// Write burst; data words follow on the link edges after the command.
	wire wr_cut = take_rd | take_preall | (take_pre & dec_ba == wr_bank);
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wr_burst_o <= 1'b0;
			wr_bank <= '0;
			wr_ap <= 1'b0;
			wr_left <= 3'h0;
		end else if (take_wr) begin
			wr_burst_o <= 1'b1;
			wr_bank <= dec_ba;
			wr_ap <= dec_ap;
			wr_left <= BURST_EDGES;
		end else if (wr_cut || wr_end) begin
			wr_burst_o <= 1'b0;
		end else if (ck_edge && wr_burst_o) begin
			wr_left <= wr_left - 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write capture: mask high clears the byte enable so the array keeps that byte.
	wire cap_load = ck_edge & wr_burst_o & (~cap_valid | wbuf.in_ready);
	wire cap_lost = ck_edge & wr_burst_o & cap_valid & ~wbuf.in_ready;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || take_wr) begin
			wr_col <= rst_n_i ? pin_s2.addr : REFRESH_ROW_RST;
		end else if (cap_load) begin
			wr_col <= wr_col + 13'h0001;
		end
		if (!rst_n_i) begin
			cap_valid <= 1'b0;
			cap_word <= '0;
			wr_overflow_o <= 1'b0;
		end else begin
			if (cap_load) begin
				cap_word <= '{wr_bank, wr_col, ~pin_s2.mask, pin_s2.dq};
			end
			cap_valid <= cap_load | (cap_valid & ~wbuf.in_ready);
			wr_overflow_o <= wr_overflow_o | cap_lost;
		end
	end

	// The buffer absorbs array stalls; capture holds its word until taken.
	assign wbuf.in_valid = cap_valid;
	assign wbuf.in_word = cap_word;
	assign wbuf.out_ready = array_wr_ready_i;
	assign array_wr_valid_o = wbuf.out_valid;
	assign array_wr_word_o = wbuf.out_word;
	lpcd_wr_buf u_wr_buf (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.bp(wbuf.store)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Refresh, mode load and the power modes.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ref_timer <= TIMER_RST;
			mrs_timer <= TIMER_RST;
			refresh_row_o <= REFRESH_ROW_RST;
			refreshing_o <= 1'b0;
			mode_busy_o <= 1'b0;
			self_refresh_o <= 1'b0;
			deep_power_down_o <= 1'b0;
		end else begin
			ref_timer <= take_aref ? REFRESH_CYC : ref_timer - 8'(ref_timer != TIMER_RST);
			mrs_timer <= take_mrs ? MODE_LOAD_CYC : mrs_timer - 8'(mrs_timer != TIMER_RST);
			refreshing_o <= take_aref | (ref_timer > 8'h01);
			mode_busy_o <= take_mrs | (mrs_timer > 8'h01);
			if (take_aref) begin
				refresh_row_o <= refresh_row_o + 13'h0001;
			end
			// Only clock enable is watched in the power modes; raising it leaves them.
			self_refresh_o <= take_sref | (self_refresh_o & ~pin_s2.cke);
			deep_power_down_o <= take_dpd | (deep_power_down_o & ~pin_s2.cke);
		end
	end

	// Registered view of each accepted command.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cmd_valid_o <= 1'b0;
			cmd_code_o <= LPCD_CMD_NONE;
			cmd_bank_o <= '0;
			cmd_addr_o <= '0;
			cmd_auto_pre_o <= 1'b0;
			mode_load_o <= 1'b0;
			mode_sel_o <= '0;
			mode_op_o <= '0;
		end else begin
			cmd_valid_o <= any_take;
			mode_load_o <= take_mrs;
			if (any_take) begin
				cmd_code_o <= dec_cmd;
				cmd_bank_o <= dec_ba;
				cmd_addr_o <= pin_s2.addr;
				cmd_auto_pre_o <= dec_ap;
			end
			if (take_mrs) begin
				mode_sel_o <= dec_ba;
				mode_op_o <= pin_s2.addr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_edge_only:
		assert property (cmd_valid_o |-> $past(ck_edge)) else $error("command off link edge");
	a_deselect_quiet:
		assert property (ck_edge && pin_s2.cs_n |=> !cmd_valid_o) else $error("deselect acted");
	a_noop_quiet:
		assert property (ck_edge && !pin_s2.cs_n && pin_s2.ras_n && pin_s2.cas_n && pin_s2.we_n
			|=> !cmd_valid_o) else $error("no-op acted");
	a_activate_open:
		assert property (cmd_valid_o && cmd_code_o == LPCD_CMD_ACT |-> bank_open_o[cmd_bank_o]
			&& bank_row[cmd_bank_o] == cmd_addr_o) else $error("activate left bank closed");
	a_close_timer:
		assert property ($fell(bank_open_o[0]) && !deep_power_down_o |-> pre_timer[0] == PRECHARGE_CYC)
			else $error("bank closed without precharge wait");
	a_read_start:
		assert property (cmd_valid_o && cmd_code_o == LPCD_CMD_RD |-> rd_burst_o
			&& rd_ap == cmd_auto_pre_o) else $error("read burst not started");
	a_write_start:
		assert property (cmd_valid_o && cmd_code_o == LPCD_CMD_WR |-> wr_burst_o
			&& wr_ap == cmd_auto_pre_o) else $error("write burst not started");
	a_auto_close:
		assert property (rd_end && rd_ap |=> !bank_open_o[$past(rd_bank)])
			else $error("auto precharge missed");
	a_mask_strobe:
		assert property (cap_load |=> cap_word.strb == ~$past(pin_s2.mask))
			else $error("byte enable not inverse of mask");
	a_precharge_all:
		assert property (take_preall |=> bank_open_o == BANKS_RST) else $error("bank left open");
	a_activate_wait:
		assert property (cmd_valid_o && cmd_code_o == LPCD_CMD_ACT && cmd_bank_o == 2'h0
			|-> $past(pre_timer[0]) == TIMER_RST) else $error("activate before precharge time");
	a_burst_stop:
		assert property (take_bst |=> !rd_burst_o && bank_open_o == $past(bank_open_o))
			else $error("terminate misbehaved");
	a_dpd_entry:
		assert property (take_dpd |=> deep_power_down_o && bank_open_o == BANKS_RST)
			else $error("deep power-down not entered");
	a_refresh_row:
		assert property (take_aref |=> refresh_row_o == $past(refresh_row_o) + 13'h0001)
			else $error("refresh row not advanced");
	a_refresh_busy:
		assert property (take_aref |=> refreshing_o [*8]) else $error("refresh ended early");
	a_sref_ignore:
		assert property (self_refresh_o && $past(self_refresh_o) |-> !cmd_valid_o)
			else $error("command in self refresh");
	a_mode_load:
		assert property (take_mrs |=> mode_load_o && mode_busy_o && mode_sel_o == $past(dec_ba))
			else $error("mode load wrong");

	c_activate: cover property (take_act);
	c_read_bst: cover property (take_rd ##[1:200] take_bst);
	c_write_burst: cover property (wr_end);
	c_self_refresh: cover property ($fell(self_refresh_o));

endmodule : lpcd_decoder
`default_nettype wire

// file: sim/lpcd_ctrl_model.sv
// Memory controller model that drives the link pins of the decoder.
// Assumes the bench calls frame() once for each link clock cycle.
`timescale 1ns/1ps
`default_nettype none
module lpcd_ctrl_model (
	input wire logic sys_clk_i,
	output logic ck_o,
	output logic ck_n_o,
	output logic cke_o,
	output logic [3:0] cmd_o,
	output logic [1:0] ba_o,
	output logic [12:0] addr_o,
	output logic [1:0] mask_o,
	output logic [15:0] dq_o
);
	// The bus starts deselected, with the link clock standing low.
	initial begin
		{ck_o, ck_n_o, cke_o, cmd_o, ba_o, addr_o, mask_o, dq_o} = {3'b011, 4'hf, 33'h0};
	end

	////////////////////////////////////////////////////////////
	// One link clock of 165 ns; it stands still between frames, so the bench
	// sends idle frames until every burst has ended.
	// The bench orders commands: precharge before a new activate, save one activate
	// sent to an open bank to be refused, activate before access, one refresh per need,
	// terminate only non-auto-precharge reads, refresh around self refresh, mode loads only when idle.
	task automatic frame(input logic k, input logic [3:0] cm, input logic [1:0] b,
		input logic [12:0] a, input logic [1:0] m, input logic [15:0] d);
		@(posedge sys_clk_i);
		#1;
		{cke_o, cmd_o, ba_o, addr_o, mask_o, dq_o} = {k, cm, b, a, m, d};
		repeat (16) @(posedge sys_clk_i);
		#1;
		{ck_o, ck_n_o} = 2'b10; // True clock rises while the complement falls.
		repeat (16) @(posedge sys_clk_i);
		#1;
		{ck_o, ck_n_o} = 2'b01;
		// Released lines show the inverse; chip select goes high and clock enable keeps its value.
		cmd_o = {1'b1, ~cm[2:0]};
		{ba_o, addr_o, mask_o, dq_o} = ~{b, a, m, d};
	endtask : frame
endmodule : lpcd_ctrl_model
`default_nettype wire

// file: sim/lpddr_command_decoder_tb.sv
// Self-checking bench of the command decoder.
// Assumes the controller model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lpddr_command_decoder_tb;
	import lpcd_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic rdy = 1'b0;
	logic stall = 1'b1;
	logic ck, ck_n, cke, cv, ap, rdb, wrb, refr, ml, mb, sr, deep_power_down, ovf, awv;
	logic [3:0] c, bopen, brdy;
	logic [1:0] ba, msk, b, cb, msel;
	logic [12:0] ad, a, col, caddr, rrow, mop;
	logic [15:0] dq;
	logic [1:0] wm [2];
	logic [15:0] wd [2];
	logic [31:0] seed = 32'ha056;
	logic [31:0] rs;
	lpcd_cmd_t code;
	lpcd_wr_word_t aw;
	lpcd_wr_word_t got [$];
	int n_fail = 0;
	int num_checks = 0;
	int n_cmd = 0;
	int n_ml = 0;
	int n_mb = 0;
	int n_rf = 0;

	always #2.5 sys_clk = ~sys_clk;

	lpcd_ctrl_model lpcd_ctrl_model_inst (.sys_clk_i(sys_clk), .ck_o(ck), .ck_n_o(ck_n),
		.cke_o(cke), .cmd_o(c), .ba_o(ba), .addr_o(ad), .mask_o(msk), .dq_o(dq));

	lpcd_decoder lpcd_decoder_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .link_ck_i(ck),
		.link_ck_n_i(ck_n), .clock_enable_i(cke), .chip_select_n_i(c[3]),
		.row_strobe_n_i(c[2]), .column_strobe_n_i(c[1]), .write_enable_n_i(c[0]),
		.bank_addr_i(ba), .addr_i(ad), .write_mask_i(msk), .dq_i(dq),
		.array_wr_ready_i(rdy), .cmd_valid_o(cv), .cmd_code_o(code), .cmd_bank_o(cb),
		.cmd_addr_o(caddr), .cmd_auto_pre_o(ap), .bank_open_o(bopen), .bank_ready_o(brdy),
		.rd_burst_o(rdb), .wr_burst_o(wrb), .refreshing_o(refr), .refresh_row_o(rrow),
		.mode_load_o(ml), .mode_busy_o(mb), .mode_sel_o(msel), .mode_op_o(mop),
		.self_refresh_o(sr), .deep_power_down_o(deep_power_down), .wr_overflow_o(ovf),
		.array_wr_valid_o(awv), .array_wr_word_o(aw));

	////////////////////////////////////////////////////////////
	// Xorshift source shared by stimulus and the array's ready line.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// The array stalls at random; words, commands, mode loads and busy cycles are counted here.
	always @(posedge sys_clk) begin
		rs = rnd();
		rdy <= #1 (!stall && rs[3]);
		if (cv === 1'b1) n_cmd <= n_cmd + 1;
		if (ml === 1'b1) n_ml <= n_ml + 1;
		if (mb === 1'b1) n_mb <= n_mb + 1;
		if (refr === 1'b1) n_rf <= n_rf + 1;
		if (awv === 1'b1 && rdy) got.push_back(aw);
	end

	function automatic lpcd_wr_word_t ex_word(logic [1:0] bk, logic [12:0] cl, logic [1:0] m,
		logic [15:0] d);
		return '{bank: bk, col: cl, strb: ~m, data: d};
	endfunction : ex_word

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic test_done();
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	// One link frame; a refused command must leave the accept count alone.
	task automatic cmd(input logic k, input logic [3:0] cm, input logic [1:0] bk,
		input logic [12:0] ad_v, input lpcd_cmd_t ex);
		int n0;
		n0 = n_cmd;
		lpcd_ctrl_model_inst.frame(k, cm, bk, ad_v, 2'(rnd()), 16'(rnd()));
		chk("cmd_count", 64'(n_cmd - n0), 64'(ex != LPCD_CMD_NONE));
		if (ex != LPCD_CMD_NONE) chk("cmd_code", 64'(code), 64'(ex));
	endtask : cmd

	////////////////////////////////////////////////////////////
	// Main sequence: each command in turn, with write data held back by a stall.
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge sys_clk);
		cmd(1'b1, {1'b1, 3'(rnd())}, 2'h0, 13'h0000, LPCD_CMD_NONE);
		cmd(1'b1, 4'h7, 2'h0, 13'h0000, LPCD_CMD_NONE);
		chk("code_idle", 64'(code), 64'(LPCD_CMD_NONE));
		b = 2'(rnd());
		a = 13'(rnd());
		cmd(1'b1, 4'h3, b, a, LPCD_CMD_ACT);
		chk("act", {bopen[b], cb, caddr}, {1'b1, b, a});
		col = 13'(rnd()) & 13'h03fe;
		cmd(1'b1, 4'h4, b, col, LPCD_CMD_WR);
		chk("wr_flags", {ap, wrb, cb, caddr}, {2'b01, b, col});
		for (int i = 0; i < 2; i++) begin
			wm[i] = (i == 0) ? 2'b01 : 2'(rnd());
			wd[i] = 16'(rnd());
			lpcd_ctrl_model_inst.frame(1'b1, 4'hf, 2'h0, 13'h0000, wm[i], wd[i]);
		end
		stall = 1'b0;
		for (int t = 0; t < 200 && got.size() < 2; t++) @(posedge sys_clk);
		if (got.size() < 2) begin
			n_fail++;
			test_done();
		end
		for (int i = 0; i < 2; i++) begin
			chk("wr_word", got[i], ex_word(b, col + 13'(i), wm[i], wd[i]));
		end
		cmd(1'b1, 4'h5, b, col | 13'h0400, LPCD_CMD_RD);
		chk("rd_ap", {ap, rdb}, 2'b11);
		cmd(1'b1, 4'hf, 2'h0, 13'h0000, LPCD_CMD_NONE);
		cmd(1'b1, 4'hf, 2'h0, 13'h0000, LPCD_CMD_NONE);
		chk("ap_close", {bopen[b], rdb, brdy[b]}, 3'b001);
		cmd(1'b1, 4'h3, b, a, LPCD_CMD_ACT);
		cmd(1'b1, 4'h3, b, a ^ 13'h0001, LPCD_CMD_NONE);
		cmd(1'b1, 4'h5, b, col, LPCD_CMD_RD);
		chk("rd_noap", {ap, rdb}, 2'b01);
		cmd(1'b1, 4'h6, 2'(rnd()), 13'(rnd()), LPCD_CMD_BST);
		chk("bst", {rdb, bopen[b]}, 2'b01);
		cmd(1'b1, 4'h3, b ^ 2'h1, a, LPCD_CMD_ACT);
		cmd(1'b1, 4'h2, b, 13'h0000, LPCD_CMD_PRE);
		chk("pre_one", {bopen[b], bopen[b ^ 2'h1], brdy[b]}, 3'b011);
		cmd(1'b1, 4'h2, 2'(rnd()), 13'h0400 | 13'(rnd()), LPCD_CMD_PREALL);
		chk("pre_all", bopen, 4'h0);
		cmd(1'b1, 4'h1, 2'(rnd()), 13'(rnd()), LPCD_CMD_AREF);
		chk("refreshing", refr, 1'b1);
		chk("refresh_row", rrow, REFRESH_ROW_RST + 13'h0001);
		for (int k = 0; k < 3; k++) begin
			a = 13'(rnd());
			cmd(1'b1, 4'h0, 2'(k), a, LPCD_CMD_MRS);
			chk("mode", {msel, mop}, {2'(k), a});
		end
		chk("mode_loads", 64'(n_ml), 64'(3));
		chk("mode_busy", 64'(n_mb), 64'(3 * MODE_LOAD_CYC));
		cmd(1'b1, 4'h1, 2'h0, 13'h0000, LPCD_CMD_AREF);
		chk("refresh_row2", rrow, REFRESH_ROW_RST + 13'h0002);
		cmd(1'b0, 4'h1, 2'(rnd()), 13'(rnd()), LPCD_CMD_SREF);
		cmd(1'b0, 4'h3, b, a, LPCD_CMD_NONE);
		chk("sref", {sr, bopen}, 5'h10);
		cmd(1'b1, 4'hf, 2'h0, 13'h0000, LPCD_CMD_NONE);
		chk("sref_exit", sr, 1'b0);
		cmd(1'b1, 4'h1, 2'h0, 13'h0000, LPCD_CMD_AREF);
		chk("refresh_row3", rrow, REFRESH_ROW_RST + 13'h0003);
		cmd(1'b1, 4'h3, b, a, LPCD_CMD_ACT);
		cmd(1'b0, 4'h6, 2'(rnd()), 13'(rnd()), LPCD_CMD_DPD);
		chk("dpd", {deep_power_down, bopen}, 5'h10);
		cmd(1'b1, 4'hf, 2'h0, 13'h0000, LPCD_CMD_NONE);
		chk("exit_ovf", {deep_power_down, ovf}, 2'b00);
		chk("refresh_len", 64'(n_rf), 64'(3 * REFRESH_CYC));
		test_done();
	end
endmodule : lpddr_command_decoder_tb
`default_nettype wire
